// *** design/io_recovery_pkg.sv ***
// Purpose: shared constants and types for the ISA I/O recovery timer
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: the control register holds 8 bits in the low byte lane
`default_nettype none
package io_recovery_pkg;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] OFS_CONTROL = 8'h4c;
   localparam logic [7:0] OFS_STATUS = 8'h50;
   localparam logic [7:0] OFS_HOLDOFF = 8'h54;
   localparam logic [7:0] CONTROL_RESET = 8'h56;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // ***************************************************
   // Control fields
   // ***************************************************
   localparam int BIT_RESERVED = 7;
   localparam int BIT_EN8 = 6;
   localparam int POS_CNT8_HI = 5;
   localparam int POS_CNT8_LO = 3;
   localparam int BIT_EN16 = 2;
   localparam int POS_CNT16_HI = 1;
   localparam int POS_CNT16_LO = 0;
   localparam logic [7:0] CONTROL_WMASK = 8'h7f;

   // ***************************************************
   // Timing, in ISA clock periods
   // ***************************************************
   localparam logic [3:0] MIN_RECOVERY = 4'h5;
   localparam logic [3:0] ZERO_CODE_ADD8 = 4'h8;
   localparam logic [3:0] ZERO_CODE_ADD16 = 4'h4;
   localparam logic [3:0] MAX_RECOVERY = 4'hd;

   // ***************************************************
   // Status fields
   // ***************************************************
   localparam int POS_ST_STATE = 0;
   localparam int POS_ST_ELAPSED = 4;
   localparam int POS_ST_NEED = 8;
   localparam int BIT_ST_PENDING = 12;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMD = 3'b010,
      ST_REC = 3'b100
   } rec_state_e;

   typedef struct packed {
      logic from_pci;
      logic wide16;
      logic sub_cycle;
   } io_req_s;

endpackage
`default_nettype wire

// *** design/pin_sync3.sv ***
// Purpose: three-stage synchroniser with agreed level and edge pulses
// Assumes: inputs arrive from outside the clk_i domain
// Notes: a change counts once stages two and three agree
`default_nettype none
module pin_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Pins and results
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         // First stage feeds only the second stage
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_reg <= INIT[g];
               s2_reg <= INIT[g];
               s3_reg <= INIT[g];
            end else if (ce_i) begin
               s1_reg <= pin_i[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               level_o[g] <= INIT[g];
               rise_o[g] <= 1'b0;
               fall_o[g] <= 1'b0;
            end else if (ce_i) begin
               rise_o[g] <= (s2_reg == s3_reg) && s3_reg && !level_o[g];
               fall_o[g] <= (s2_reg == s3_reg) && !s3_reg && level_o[g];
               if (s2_reg == s3_reg) begin
                  level_o[g] <= s3_reg;
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// *** design/io_recovery_timer.sv ***
// Purpose: spaces forwarded ISA I/O cycles by a programmable recovery
// Assumes: classic Wishbone slave; ISA clock and strobes are pins
// Notes: the bridge asserts a request and starts BALE only on io_go_o
//
// Functional notes
// (RULE1) Spacing applies only to PCI-originated 8 and 16-bit ISA I/O cycles.
// (RULE2) At least five ISA clocks always separate consecutive I/O cycles; here only PCI requests wait, counted from the last granted PCI strobe end.
// (RULE3) Interval runs from strobe rising edge to next BALE falling edge.
// (RULE4) Extra recovery adds whole ISA clocks per width's programmed count.
// (RULE5) Byte assembly sub-cycles get no extra recovery beyond minimum.
// (RULE6) Bit 6 enables 8-bit extra count; clear means minimum only.
// (RULE7) Bits 5:3 add 1 to 7 clocks; code 000 adds 8, total 13.
// (RULE8) Bit 2 enables 16-bit extra count; clear means minimum only.
// (RULE9) Bits 1:0 add 1 to 3 clocks; code 00 adds 4, total 9.
// (RULE10) Reset value 56h: both enables set, both counts add two.
// (RULE11) Reserved bit 7 always reads zero.
// (RULE12) BALE held off until recovery counter, restarted per strobe, ends; here it restarts only at a granted PCI strobe end.
`default_nettype none
module io_recovery_timer
   import io_recovery_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Cycle request from the bridge
   input wire logic req_valid_i,
   input wire io_req_s req_i,
   output logic io_go_o,
   output logic recovering_o,
   // ISA pins
   input wire logic sysclk_i,
   input wire logic ior_n_i,
   input wire logic iow_n_i
);

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic isa_tick;
   logic strobe_end;

   // Three flops per pin; SYSCLK shares the path with the strobes so
   // their edges keep the same latency and line up cycle for cycle
   pin_sync3 #(
      .WIDTH(3),
      .INIT(3'h6)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i({iow_n_i, ior_n_i, sysclk_i}),
      .level_o(),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // One ISA clock counts per synchronised rising edge of SYSCLK
   assign isa_tick = pin_rise[0];
   // RULE3 strobe end
   // Either command strobe going high ends the cycle
   assign strobe_end = pin_rise[1] | pin_rise[2];

   // ***************************************************
   // Recovery decode
   // ***************************************************
   logic [7:0] control_reg;

   // Total ISA clocks a request must wait after the last granted PCI strobe end
   function automatic logic [3:0] needed_clocks(
      input logic [7:0] ctl,
      input io_req_s rq
   );
      logic [3:0] add;
      add = 4'h0;
      if (rq.wide16) begin
         // RULE8 16-bit enable
         if (ctl[BIT_EN16]) begin
            // RULE9 16-bit decode
            add = {2'b00, ctl[POS_CNT16_HI:POS_CNT16_LO]};
            if (add == 4'h0) begin
               add = ZERO_CODE_ADD16;
            end
         end
      end else begin
         // RULE6 8-bit enable
         if (ctl[BIT_EN8]) begin
            // RULE7 8-bit decode
            add = {1'b0, ctl[POS_CNT8_HI:POS_CNT8_LO]};
            if (add == 4'h0) begin
               add = ZERO_CODE_ADD8;
            end
         end
      end
      // RULE5 sub-cycles minimum
      if (rq.sub_cycle) begin
         add = 4'h0;
      end
      // RULE4 whole clock steps
      // RULE2 five clock floor
      needed_clocks = MIN_RECOVERY + add;
   endfunction

   // ***************************************************
   // Recovery state
   // ***************************************************
   rec_state_e state_reg;
   rec_state_e state_next;
   logic [3:0] elapsed_reg;
   logic [3:0] need_now;
   logic may_go;

   assign need_now = needed_clocks(control_reg, req_i);

   // ***************************************************
   // Command strobe tracking
   // ***************************************************
   logic strobe_begin;
   logic strobe_seen_reg;
   logic cmd_done;

   assign strobe_begin = pin_fall[1] | pin_fall[2];

   // An end only closes the granted cycle once its own strobe went low,
   // so a strobe already in flight at the grant cannot cut recovery short
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_seen_reg <= 1'b0;
      end else if (ce_i) begin
         if (state_reg == ST_CMD && strobe_begin) begin
            strobe_seen_reg <= 1'b1;
         end else if (state_reg != ST_CMD) begin
            strobe_seen_reg <= 1'b0;
         end
      end
   end

   // RULE3 granted strobe end
   assign cmd_done = strobe_end && strobe_seen_reg;

   // RULE1 PCI cycles only
   // RULE12 hold off BALE
   // Cycles from ISA masters or DMA never wait on this timer
   always_comb begin
      may_go = 1'b0;
      if (req_valid_i && !io_go_o) begin
         if (!req_i.from_pci) begin
            may_go = 1'b1;
         end else if (state_reg != ST_CMD) begin
            may_go = (elapsed_reg >= need_now);
         end
      end
   end

   // Recovery falls back to idle once the longest total has passed
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (may_go && req_i.from_pci) begin
               state_next = ST_CMD;
            end
         end
         ST_CMD: begin
            if (cmd_done) begin
               state_next = ST_REC;
            end
         end
         ST_REC: begin
            if (may_go && req_i.from_pci) begin
               state_next = ST_CMD;
            end else if (elapsed_reg >= MAX_RECOVERY) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // RULE12 counter restart
   // Saturating count of ISA clocks since the last granted PCI strobe end
   // Saturating at the longest total keeps the count narrow and lets the
   // first request after reset go without waiting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         elapsed_reg <= MAX_RECOVERY;
      end else if (ce_i) begin
         if (cmd_done && state_reg == ST_CMD) begin
            elapsed_reg <= 4'h0;
         end else if (isa_tick && elapsed_reg < MAX_RECOVERY) begin
            elapsed_reg <= elapsed_reg + 4'h1;
         end
      end
   end

   // ***************************************************
   // Request outputs
   // ***************************************************
   // The grant is a single pulse; a PCI request still held after it must
   // wait for the next recovery like any other
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_go_o <= 1'b0;
      end else if (ce_i) begin
         io_go_o <= may_go;
      end
   end

   // Recovery is reported only while the count can still hold a request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         recovering_o <= 1'b0;
      end else if (ce_i) begin
         recovering_o <= (state_next == ST_REC) &&
                         (elapsed_reg < MAX_RECOVERY);
      end
   end

   // ***************************************************
   // Hold-off counter
   // ***************************************************
   // Counts PCI requests that had to wait for recovery
   logic [15:0] holdoff_reg;
   logic waiting_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         waiting_reg <= 1'b0;
         holdoff_reg <= 16'h0000;
      end else if (ce_i) begin
         waiting_reg <= req_valid_i && req_i.from_pci && !may_go &&
                        !io_go_o;
         if (req_valid_i && req_i.from_pci && !may_go && !io_go_o &&
             !waiting_reg) begin
            holdoff_reg <= holdoff_reg + 16'h0001;
         end
      end
   end

   // ***************************************************
   // Wishbone slave
   // ***************************************************
   logic bus_req;
   logic bus_write;
   logic [31:0] read_mux;

   // Registers sit on word boundaries; byte offset bits are ignored
   function automatic logic [7:0] word_addr(input logic [7:0] adr);
      word_addr = {adr[7:2], 2'b00};
   endfunction

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_write = bus_req && wb_we_i;

   // One cycle answer; the ack drops the cycle after it rises
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
      end
   end

   // ***************************************************
   // Control register
   // ***************************************************
   // RULE10 reset value
   // Only the low byte lane carries the control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_reg <= CONTROL_RESET;
      end else if (ce_i) begin
         if (bus_write && wb_sel_i[0] &&
             word_addr(wb_adr_i) == OFS_CONTROL) begin
            control_reg <= wb_dat_i[7:0] & CONTROL_WMASK;
         end
      end
   end

   // ***************************************************
   // Read path
   // ***************************************************
   always_comb begin
      read_mux = UNMAPPED_DATA;
      case (word_addr(wb_adr_i))
         OFS_CONTROL: begin
            // RULE11 reserved reads zero
            read_mux[7:0] = control_reg & CONTROL_WMASK;
         end
         // Status shows the live count so software can watch recovery
         OFS_STATUS: begin
            read_mux[POS_ST_STATE +: 3] = state_reg;
            read_mux[POS_ST_ELAPSED +: 4] = elapsed_reg;
            read_mux[POS_ST_NEED +: 4] = need_now;
            read_mux[BIT_ST_PENDING] = req_valid_i;
         end
         OFS_HOLDOFF: begin
            read_mux[15:0] = holdoff_reg;
         end
         default: begin
            read_mux = UNMAPPED_DATA;
         end
      endcase
   end

   // Read data stands only in the ack cycle; zero otherwise keeps the
   // bus quiet for wired-or fabrics
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= UNMAPPED_DATA;
      end else if (ce_i) begin
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= read_mux;
         end else begin
            wb_dat_o <= UNMAPPED_DATA;
         end
      end
   end

endmodule
`default_nettype wire

// *** dv/isa_io_slave_model.sv ***
// Purpose: ISA I/O slave side with free ISA clock and strobes
// Assumes: one strobe per grant, three ISA clocks wide
// Notes: since_o counts ISA clocks after the last strobe ended
`default_nettype none
module isa_io_slave_model (
   // Bridge side
   input wire logic clk_i,
   input wire logic go_i,
   // ISA pins
   output logic sysclk_o,
   output logic ior_n_o,
   output logic iow_n_o,
   output logic [4:0] since_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   logic [4:0] cnt = 5'h1f;
   assign since_o = cnt;
   // ****************
   // Free ISA clock
   // ****************
   initial begin
      sysclk_o = 1'b0;
      #3;
      forever #100 sysclk_o = ~sysclk_o;
   end
   // Strobes move on ISA clock edges, idle high as pulled up
   initial begin
      {ior_n_o, iow_n_o, wr} = 3'b110;
      forever begin
         @(posedge clk_i iff go_i === 1'b1);
         @(posedge sysclk_o);
         ior_n_o <= wr;
         iow_n_o <= !wr;
         repeat (3) @(posedge sysclk_o);
         {ior_n_o, iow_n_o} <= 2'b11;
         wr = !wr;
      end
   end
   always @(posedge sysclk_o) begin
      if (!(ior_n_o && iow_n_o)) begin
         cnt <= 5'h0;
      end else if (cnt != 5'h1f) begin
         cnt <= cnt + 5'h1;
      end
   end
endmodule
`default_nettype wire

// *** dv/io_recovery_timer_chk.sv ***
// Purpose: port checks for the recovery timer
// Assumes: pins are sampled raw in the clk_i domain
// Notes: raw ISA clock counts restart at every strobe, the synced count only at a granted PCI strobe end
`default_nettype none
module io_recovery_timer_chk
   import io_recovery_pkg::*;
(
   // Bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Request and pins
   input wire logic req_valid_i,
   input wire io_req_s req_i,
   input wire logic io_go_o,
   input wire logic sysclk_i,
   input wire logic ior_n_i,
   input wire logic iow_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_reg;
   logic [3:0] gap_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Raw ISA clocks since a strobe ended
   always_ff @(posedge clk_i) begin
      sclk_reg <= sysclk_i;
      if (rst_i || !(ior_n_i && iow_n_i)) begin
         gap_reg <= rst_i ? 4'hd : 4'h0;
      end else if (sysclk_i && !sclk_reg && gap_reg != 4'hd) begin
         gap_reg <= gap_reg + 4'h1;
      end
   end
   // ****************
   // Assertions
   // ****************
   property p_ack1;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_take: assert property (p_take) else $error("no ack");
   property p_dat0;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat0: assert property (p_dat0) else $error("data outside ack");
   property p_rsvd;
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFS_CONTROL
         |-> wb_dat_o[31:7] == 25'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
   property p_unmap;
      wb_ack_o && $past(wb_adr_i) > 8'h57 |-> wb_dat_o == UNMAPPED_DATA;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   property p_go1;
      io_go_o |=> !io_go_o;
   endproperty
   a_go1: assert property (p_go1) else $error("grant too long");
   property p_cause;
      io_go_o |-> $past(req_valid_i);
   endproperty
   a_cause: assert property (p_cause) else $error("grant unasked");
   property p_gap;
      io_go_o && $past(req_i.from_pci) |-> gap_reg >= 4'h5;
   endproperty
   a_gap: assert property (p_gap) else $error("gap short");
   property p_bypass;
      req_valid_i && !req_i.from_pci && !io_go_o |-> ##[1:2] io_go_o;
   endproperty
   a_bypass: assert property (p_bypass) else $error("slow");
   cover property (io_go_o && gap_reg == 4'hd);
   cover property (wb_ack_o && $past(wb_we_i));
   cover property (io_go_o && !$past(req_i.from_pci));
endmodule
bind io_recovery_timer io_recovery_timer_chk u_io_recovery_timer_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_i(req_i),
   .io_go_o(io_go_o), .sysclk_i(sysclk_i), .ior_n_i(ior_n_i),
   .iow_n_i(iow_n_i));
`default_nettype wire

// *** dv/io_recovery_timer_tb_top.sv ***
// Purpose: register and spacing tests for the recovery timer
// Assumes: ISA clock of 200 ns from the slave model
// Notes: spacing is the model's ISA clock count at each grant
`default_nettype none
module io_recovery_timer_tb_top
   import io_recovery_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CTL [15] = '{8'h40, 8'h48, 8'h50, 8'h58, 8'h60,
      8'h68, 8'h70, 8'h78, 8'h04, 8'h05, 8'h06, 8'h07, 8'h07, 8'h78, 8'hff};
   localparam logic [2:0] KIND [15] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
      3'h4, 3'h4, 3'h4, 3'h6, 3'h6, 3'h6, 3'h6, 3'h4, 3'h6, 3'h5};
   localparam logic [4:0] GAP [15] = '{5'hd, 5'h6, 5'h7, 5'h8, 5'h9,
      5'ha, 5'hb, 5'hc, 5'h9, 5'h6, 5'h7, 5'h8, 5'h5, 5'h5, 5'h5};
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic req_valid_i, io_go_o, recovering_o, sysclk_i, ior_n_i, iow_n_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [4:0] since, seen;
   io_req_s req_i;
   int fails, num_checks, n, rcv;
   io_recovery_timer u_io_recovery_timer (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_i(req_i),
      .io_go_o(io_go_o), .recovering_o(recovering_o), .sysclk_i(sysclk_i),
      .ior_n_i(ior_n_i), .iow_n_i(iow_n_i));
   isa_io_slave_model u_isa_io_slave_model (
      .clk_i(clk_i), .go_i(io_go_o), .sysclk_o(sysclk_i),
      .ior_n_o(ior_n_i), .iow_n_o(iow_n_i), .since_o(since));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded waits: a hang counts as a mismatch and ends the run
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hf, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
      if (k >= 50) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic xfer(input io_req_s r, output int k, output int rc);
      k = 0;
      rc = 0;
      req_i <= r;
      req_valid_i <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
         rc += int'(recovering_o === 1'b1);
      end while (io_go_o !== 1'b1 && k < 3000);
      seen = since;
      req_valid_i <= 1'b0;
      @(posedge clk_i);
      if (k >= 3000) begin
         fails++;
         report_and_stop();
      end
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i} = 5'h10;
      {wb_adr_i, wb_sel_i, wb_dat_i, req_i} = {8'h0, 4'hf, 32'h0, 3'h0};
      fails = 0;
      num_checks = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, OFS_CONTROL, 32'h0, rd);
      check(rd, {24'h0, CONTROL_RESET});
      wb(1'b0, 8'h60, 32'h0, rd);
      check(rd, UNMAPPED_DATA);
      xfer(io_req_s'(3'h4), n, rcv);
      check(32'(rcv), 32'h0);
      $display("register test done");
      for (int i = 0; i < 15; i++) begin
         wb(1'b1, OFS_CONTROL, {24'h0, CTL[i]}, rd);
         wb(1'b0, OFS_CONTROL, 32'h0, rd);
         check(rd, {24'h0, CTL[i] & CONTROL_WMASK});
         xfer(io_req_s'(KIND[i]), n, rcv);
         check({27'h0, seen}, {27'h0, GAP[i]});
         check(32'(rcv > 0), 32'h1);
      end
      // Non-PCI request granted within three clocks; hold-off count reads 15
      xfer(io_req_s'(3'h0), n, rcv);
      check(32'(n > 3), 32'h0);
      wb(1'b0, OFS_HOLDOFF, 32'h0, rd);
      check(rd, 32'hf);
      $display("spacing test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
